// ### hw/mdcm_link_if.sv
`default_nettype none
interface mdcm_link_if;
   import mdcm_pkg::*;
   logic       mcuWe;
   logic       mcuRe;
   logic [2:0] mcuSel;
   logic [7:0] mcuWdata;
   logic [7:0] mcuRdata;
   logic [7:0] mcuStatus;
   modport device (input mcuWe, mcuRe, mcuSel, mcuWdata,
                   output mcuRdata, mcuStatus);
   modport mcu (output mcuWe, mcuRe, mcuSel, mcuWdata,
                input mcuRdata, mcuStatus);
endinterface
`default_nettype wire

// ### hw/mdcm_mailbox.sv
// Behaviour
// - One 18-bit word over three bytes.
// - Word bits: high 17:10, mid 9:2, low 1:0.
// - Address: low byte 7:0, high bits 1:0.
// - High address bit 2: 0 read, 1 write.
// - Read, Write, Busy flags in status byte.
// - Host writes data low/mid/high, address high, low.
// - Low address write for write sets Write, Busy.
// - DSP reading incoming word clears Write, Busy.
// - Read request sets Read, Busy, read interrupt.
// - DSP writing outgoing word clears Read.
// - Host fetches high, mid, low after Read clears.
// - Read Busy clears after low byte fetched.
// - Host waits for Busy clear before transfers.
`include "mdcm_map.svh"
`default_nettype none
module mdcm_mailbox
   import mdcm_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   mdcm_link_if.device     link,
   output var  mdcm_word_t dspWordIn,
   output var  mdcm_addr_t dspAddr,
   output var  logic       dspWriteIrq,
   output var  logic       dspReadIrq,
   input  wire logic       dspInRead,
   input  wire logic       dspOutWrite,
   input  wire mdcm_word_t dspWordOut
);
   typedef struct packed {
      logic [7:0] inHigh;
      logic [7:0] inMid;
      logic [7:0] inLow;
      logic [7:0] adrHigh;
      logic [7:0] adrLow;
      mdcm_word_t outWord;
      logic       readFlag;
      logic       writeFlag;
      logic       busyFlag;
      logic       wIrq;
      logic       rIrq;
      logic [7:0] rdata;
   } mdcm_state_t;

   mdcm_state_t st_reg;
   mdcm_state_t st_next;

   // Strobes decoded from the byte port of the microcontroller.
   logic wrInLow;
   logic wrInMid;
   logic wrInHigh;
   logic wrAdrHigh;
   logic wrAdrLow;
   logic rdOutLow;
   logic reqIsWrite;
   logic setWrite;
   logic setRead;

   assign wrInLow = link.mcuWe && (link.mcuSel == `MDCM_SEL_IN_LOW);
   assign wrInMid = link.mcuWe && (link.mcuSel == `MDCM_SEL_IN_MID);
   assign wrInHigh = link.mcuWe && (link.mcuSel == `MDCM_SEL_IN_HIGH);
   assign wrAdrHigh = link.mcuWe && (link.mcuSel == `MDCM_SEL_ADR_HIGH);
   assign wrAdrLow = link.mcuWe && (link.mcuSel == `MDCM_SEL_ADR_LOW);
   assign rdOutLow = link.mcuRe && (link.mcuSel == `MDCM_SEL_OUT_LOW);
   // The direction is the one held when the low address byte lands.
   assign reqIsWrite = st_reg.adrHigh[`MDCM_ADRHI_DIR];
   assign setWrite = wrAdrLow && reqIsWrite;
   assign setRead = wrAdrLow && !reqIsWrite;

   // Picks the outgoing byte that a select names; other selects read 0.
   function automatic logic [7:0] outByte(input logic [2:0] sel,
                                          input mdcm_word_t word);
      logic [7:0] b;
      b = `MDCM_RESET_BYTE;
      case (sel)
         `MDCM_SEL_OUT_HIGH: begin
            b = word[17:10];
         end
         `MDCM_SEL_OUT_MID: begin
            b = word[9:2];
         end
         `MDCM_SEL_OUT_LOW: begin
            b = {6'h00, word[1:0]};
         end
         default: begin
            b = `MDCM_RESET_BYTE;
         end
      endcase
      return b;
   endfunction

   // Assembles the status byte; spare bits read as zero.
   function automatic logic [7:0] statusByte(input logic rd,
                                             input logic wr,
                                             input logic busy);
      logic [7:0] s;
      s = `MDCM_RESET_BYTE;
      s[`MDCM_STAT_READ] = rd;
      s[`MDCM_STAT_WRITE] = wr;
      s[`MDCM_STAT_BUSY] = busy;
      return s;
   endfunction

   always_comb begin
      st_next = st_reg;

      // Incoming word, one byte per strobe.
      if (wrInLow) begin
         st_next.inLow = link.mcuWdata;
      end
      if (wrInMid) begin
         st_next.inMid = link.mcuWdata;
      end
      if (wrInHigh) begin
         st_next.inHigh = link.mcuWdata;
      end

      // The high address byte stays until it is written again.
      if (wrAdrHigh) begin
         st_next.adrHigh = link.mcuWdata;
      end
      if (wrAdrLow) begin
         st_next.adrLow = link.mcuWdata;
      end

      // Outgoing word, written by the DSP.
      if (dspOutWrite) begin
         st_next.outWord = dspWordOut;
      end

      // A new request sets its flags even if a clear falls in the cycle.
      if (setWrite) begin
         st_next.writeFlag = 1'b1;
      end else if (dspInRead) begin
         st_next.writeFlag = 1'b0;
      end

      if (setRead) begin
         st_next.readFlag = 1'b1;
      end else if (dspOutWrite) begin
         st_next.readFlag = 1'b0;
      end

      // While a write is pending only the DSP may release Busy.
      if (wrAdrLow) begin
         st_next.busyFlag = 1'b1;
      end else if (dspInRead) begin
         st_next.busyFlag = 1'b0;
      end else if (rdOutLow && !st_reg.writeFlag) begin
         st_next.busyFlag = 1'b0;
      end

      // Interrupts are one-cycle pulses toward the DSP.
      st_next.wIrq = setWrite;
      st_next.rIrq = setRead;

      // The read-back byte stands one cycle after its select.
      st_next.rdata = outByte(link.mcuSel, st_reg.outWord);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign link.mcuRdata = st_reg.rdata;
   assign link.mcuStatus = statusByte(st_reg.readFlag, st_reg.writeFlag,
                                      st_reg.busyFlag);
   assign dspWordIn = {st_reg.inHigh, st_reg.inMid, st_reg.inLow[1:0]};
   assign dspAddr = {st_reg.adrHigh[1:0], st_reg.adrLow};
   assign dspWriteIrq = st_reg.wIrq;
   assign dspReadIrq = st_reg.rIrq;
endmodule // mdcm_mailbox
`default_nettype wire

// ### hw/mdcm_map.svh
`ifndef MDCM_MAP_SVH
`define MDCM_MAP_SVH
// Byte register selects on the microcontroller port.
`define MDCM_SEL_IN_LOW    3'h0
`define MDCM_SEL_IN_MID    3'h1
`define MDCM_SEL_IN_HIGH   3'h2
`define MDCM_SEL_ADR_HIGH  3'h3
`define MDCM_SEL_ADR_LOW   3'h4
`define MDCM_SEL_OUT_HIGH  3'h5
`define MDCM_SEL_OUT_MID   3'h6
`define MDCM_SEL_OUT_LOW   3'h7
// Status byte bit positions.
`define MDCM_STAT_READ     0
`define MDCM_STAT_WRITE    1
`define MDCM_STAT_BUSY     2
// Direction bit inside the high address byte.
`define MDCM_ADRHI_DIR     2
`define MDCM_RESET_BYTE    8'h00
`endif

// ### hw/mdcm_mcu_end.sv
`include "mdcm_map.svh"
`default_nettype none
module mdcm_mcu_end
   import mdcm_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   mdcm_link_if.mcu        link,
   input  wire logic       reqValid,
   input  wire mdcm_dir_t  reqDir,
   input  wire mdcm_addr_t reqAddr,
   input  wire mdcm_word_t reqWord,
   output var  logic       reqReady,
   output var  logic       rspValid,
   output var  mdcm_word_t rspWord
);
   typedef enum logic [3:0] {
      S_IDLE, S_WAITB, S_DLO, S_DMI, S_DHI, S_AHI, S_ALO,
      S_POLL, S_FHI, S_FMI, S_FLO, S_FCAP, S_DONE
   } mdcm_mst_t;

   typedef struct packed {
      mdcm_mst_t  fsm;
      mdcm_dir_t  dir;
      mdcm_addr_t addr;
      mdcm_word_t word;
      logic       we;
      logic       re;
      logic [2:0] sel;
      logic [7:0] wdata;
      logic       ready;
      logic       rv;
   } mdcm_mcu_t;

   mdcm_mcu_t st_reg;
   mdcm_mcu_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.we = 1'b0;
      st_next.re = 1'b0;
      st_next.rv = 1'b0;
      st_next.ready = 1'b0;
      case (st_reg.fsm)
         S_IDLE: begin
            st_next.ready = 1'b1;
            if (reqValid && st_reg.ready) begin
               st_next.ready = 1'b0;
               st_next.dir = reqDir;
               st_next.addr = reqAddr;
               st_next.word = reqWord;
               st_next.fsm = S_WAITB;
            end
         end
         S_WAITB: begin
            if (!link.mcuStatus[`MDCM_STAT_BUSY]) begin
               st_next.fsm = (st_reg.dir == MDCM_WR) ? S_DLO : S_AHI;
            end
         end
         S_DLO: begin
            st_next.we = 1'b1;
            st_next.sel = `MDCM_SEL_IN_LOW;
            st_next.wdata = {6'h00, st_reg.word[1:0]};
            st_next.fsm = S_DMI;
         end
         S_DMI: begin
            st_next.we = 1'b1;
            st_next.sel = `MDCM_SEL_IN_MID;
            st_next.wdata = st_reg.word[9:2];
            st_next.fsm = S_DHI;
         end
         S_DHI: begin
            st_next.we = 1'b1;
            st_next.sel = `MDCM_SEL_IN_HIGH;
            st_next.wdata = st_reg.word[17:10];
            st_next.fsm = S_AHI;
         end
         S_AHI: begin
            st_next.we = 1'b1;
            st_next.sel = `MDCM_SEL_ADR_HIGH;
            st_next.wdata = {5'h00, st_reg.dir == MDCM_WR,
                             st_reg.addr[9:8]};
            st_next.fsm = S_ALO;
         end
         S_ALO: begin
            st_next.we = 1'b1;
            st_next.sel = `MDCM_SEL_ADR_LOW;
            st_next.wdata = st_reg.addr[7:0];
            st_next.fsm = (st_reg.dir == MDCM_WR) ? S_DONE : S_POLL;
         end
         S_POLL: begin
            // Status lags the low address write by one cycle.
            if (!st_reg.we && !link.mcuStatus[`MDCM_STAT_READ]) begin
               st_next.re = 1'b1;
               st_next.sel = `MDCM_SEL_OUT_HIGH;
               st_next.fsm = S_FHI;
            end
         end
         S_FHI: begin
            st_next.re = 1'b1;
            st_next.sel = `MDCM_SEL_OUT_MID;
            st_next.fsm = S_FMI;
         end
         S_FMI: begin
            // Each byte stands one cycle after its select was shown.
            st_next.re = 1'b1;
            st_next.sel = `MDCM_SEL_OUT_LOW;
            st_next.word[17:10] = link.mcuRdata;
            st_next.fsm = S_FLO;
         end
         S_FLO: begin
            st_next.word[9:2] = link.mcuRdata;
            st_next.fsm = S_FCAP;
         end
         S_FCAP: begin
            st_next.word[1:0] = link.mcuRdata[1:0];
            st_next.rv = 1'b1;
            st_next.fsm = S_DONE;
         end
         S_DONE: st_next.fsm = S_IDLE;
         default: st_next.fsm = S_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign link.mcuWe = st_reg.we;
   assign link.mcuRe = st_reg.re;
   assign link.mcuSel = st_reg.sel;
   assign link.mcuWdata = st_reg.wdata;
   assign reqReady = st_reg.ready;
   assign rspValid = st_reg.rv;
   assign rspWord = st_reg.word;
endmodule // mdcm_mcu_end
`default_nettype wire

// ### hw/mdcm_pkg.sv
`default_nettype none
package mdcm_pkg;
   typedef logic [17:0] mdcm_word_t;
   typedef logic [9:0]  mdcm_addr_t;
   typedef enum logic { MDCM_RD, MDCM_WR } mdcm_dir_t;
endpackage
`default_nettype wire

// ### verification/mcu_dsp_control_mailbox_test.sv
`default_nettype none
module mcu_dsp_control_mailbox_test import mdcm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_n, reqValid, reqReady, rspValid;
   logic dspWriteIrq, dspReadIrq, dspInRead, dspOutWrite;
   mdcm_dir_t reqDir;
   mdcm_addr_t reqAddr, dspAddr;
   mdcm_word_t reqWord, rspWord, dspWordIn, dspWordOut;
   int num_errors = 0;
   int compares = 0;
   mdcm_addr_t at [4] = '{10'h3ff, 10'h000, 10'h155, 10'h2aa};
   mdcm_word_t wt [4] = '{18'h3ffff, 18'h00001, 18'h2aaaa, 18'h15555};
   mdcm_link_if link ();
   mdcm_mailbox u_mdcm_mailbox (.mclk, .rst_n, .link, .dspWordIn, .dspAddr,
      .dspWriteIrq, .dspReadIrq, .dspInRead, .dspOutWrite, .dspWordOut);
   mdcm_mcu_end u_mdcm_mcu_end (.mclk, .rst_n, .link, .reqValid, .reqDir,
      .reqAddr, .reqWord, .reqReady, .rspValid, .rspWord);
   mdcm_link_assertions u_mdcm_link_assertions (.mclk, .rst_n,
      .mcuWe(link.mcuWe), .mcuRe(link.mcuRe), .mcuSel(link.mcuSel),
      .mcuWdata(link.mcuWdata), .mcuRdata(link.mcuRdata),
      .mcuStatus(link.mcuStatus));
   task automatic end_sim();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic waitHi(ref logic s);
      for (int i = 0; i < 60; i++) begin
         @(negedge mclk);
         if (s === 1'b1) return;
      end
      num_errors++;
      $display("Error %0t: wait ran out", $time);
      end_sim();
   endtask
   task automatic xfer(mdcm_dir_t d, mdcm_addr_t a, mdcm_word_t w);
      waitHi(reqReady);
      reqValid = 1'b1;
      reqDir = d;
      reqAddr = a;
      reqWord = w;
      @(negedge mclk);
      reqValid = 1'b0;
      if (d == MDCM_WR) begin
         waitHi(dspWriteIrq);
         chk(dspWordIn, w);
         chk(18'(dspAddr), 18'(a));
         chk(18'(link.mcuStatus), 18'h6);
         dspInRead = 1'b1;
         @(negedge mclk);
         dspInRead = 1'b0;
         chk(18'(link.mcuStatus), 18'h0);
         chk(18'(dspWriteIrq), 18'h0);
      end else begin
         waitHi(dspReadIrq);
         chk(18'(dspAddr), 18'(a));
         chk(18'(link.mcuStatus), 18'h5);
         dspOutWrite = 1'b1;
         dspWordOut = w;
         @(negedge mclk);
         dspOutWrite = 1'b0;
         dspWordOut = ~w;
         chk(18'(link.mcuStatus), 18'h4);
         chk(18'(dspReadIrq), 18'h0);
         waitHi(rspValid);
         chk(rspWord, w);
         repeat (3) @(negedge mclk);
         chk(18'(link.mcuStatus), 18'h0);
         chk(18'(dspAddr), 18'(a));
      end
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      {rst_n, reqValid, dspInRead, dspOutWrite} = 4'h0;
      reqDir = MDCM_RD;
      reqAddr = 10'h000;
      {reqWord, dspWordOut} = 36'h0;
      repeat (20) @(negedge mclk);
      rst_n = 1'b1;
      chk(18'({link.mcuStatus, dspWriteIrq, dspReadIrq}), 18'h0);
      for (int i = 0; i < 4; i++) begin
         xfer(MDCM_WR, at[i], wt[i]);
         xfer(MDCM_RD, at[i], ~wt[i]);
      end
      end_sim();
   end
endmodule // mcu_dsp_control_mailbox_test
`default_nettype wire

// ### verification/mdcm_link_assertions.sv
`default_nettype none
module mdcm_link_assertions (
   input wire logic       mclk,
   input wire logic       rst_n,
   input wire logic       mcuWe,
   input wire logic       mcuRe,
   input wire logic [2:0] mcuSel,
   input wire logic [7:0] mcuWdata,
   input wire logic [7:0] mcuRdata,
   input wire logic [7:0] mcuStatus
);
   timeunit 1ns;
   timeprecision 1ps;
   logic dirReg;
   logic loAdr;
   assign loAdr = mcuWe && mcuSel == 3'h4;
   // Direction bit of the last high address byte written.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) dirReg <= 1'b0;
      else if (mcuWe && mcuSel == 3'h3) dirReg <= mcuWdata[2];
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_wr_set; loAdr && dirReg |=> mcuStatus[2:0] == 3'h6; endproperty
   a_wr_set: assert property (p_wr_set) else $error("write flags");
   property p_rd_set; loAdr && !dirReg |=> mcuStatus[2:0] == 3'h5; endproperty
   a_rd_set: assert property (p_rd_set) else $error("read flags");
   property p_rsv; mcuStatus[7:3] == 5'h00; endproperty
   a_rsv: assert property (p_rsv) else $error("status spare bits");
   property p_rst; $rose(rst_n) |-> mcuStatus == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("flags after reset");
   property p_rd_cause;
      $rose(mcuStatus[0]) |-> $past(loAdr && !dirReg);
   endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("read flag");
   property p_wr_cause;
      $rose(mcuStatus[1]) |-> $past(loAdr && dirReg);
   endproperty
   a_wr_cause: assert property (p_wr_cause) else $error("write flag");
   property p_wr_busy; mcuStatus[1] |-> mcuStatus[2]; endproperty
   a_wr_busy: assert property (p_wr_busy) else $error("busy lost");
   property p_busy_fall;
      $fell(mcuStatus[2]) && !$past(mcuStatus[1])
         |-> $past(mcuRe && mcuSel == 3'h7);
   endproperty
   a_busy_fall: assert property (p_busy_fall) else $error("busy fell");
   property p_rd_done;
      mcuRe && mcuSel == 3'h7 && mcuStatus[2:0] == 3'h4 && !loAdr
         |=> !mcuStatus[2];
   endproperty
   a_rd_done: assert property (p_rd_done) else $error("busy held");
   property p_rdata_spare;
      mcuSel < 3'h5 |=> mcuRdata == 8'h00;
   endproperty
   a_rdata_spare: assert property (p_rdata_spare)
      else $error("spare read byte");
   property p_rdata_low;
      mcuSel == 3'h7 |=> mcuRdata[7:2] == 6'h00;
   endproperty
   a_rdata_low: assert property (p_rdata_low) else $error("low byte");
   c_wr: cover property (loAdr && dirReg);
   c_rd: cover property (loAdr && !dirReg);
   c_done: cover property (mcuRe && mcuSel == 3'h7);
endmodule // mdcm_link_assertions
`default_nettype wire
